// [nvram_host_pkg.sv]
// Package: timing, states and carriers for the nonvolatile SRAM host controller
package nvram_host_pkg;
   localparam int CLK_MHZ          = 40;
   localparam int ADDR_W           = 15;
   localparam int DATA_W           = 8;
   // Times in their own units, as printed
   localparam int READ_CYC_FAST_NS = 25;
   localparam int READ_CYC_SLOW_NS = 45;
   localparam int WRITE_PULSE_NS   = 30;
   localparam int SAVE_PULSE_NS    = 15;
   localparam int SEQ_LATENCY_US   = 100;
   localparam int RESTORE_MAX_MS   = 20;
   localparam int STORE_MAX_MS     = 8;
   // Cycle counts, least times rounded up
   localparam int READ_CYC_FAST    = (READ_CYC_FAST_NS * CLK_MHZ + 999) / 1000;
   localparam int READ_CYC_SLOW    = (READ_CYC_SLOW_NS * CLK_MHZ + 999) / 1000;
   localparam int WRITE_CYC        = (WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int SAVE_PULSE_CYC   = (SAVE_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int SEQ_LATENCY_CYC  = SEQ_LATENCY_US * CLK_MHZ;
   localparam int RESTORE_CYC      = RESTORE_MAX_MS * 1000 * CLK_MHZ;
   localparam int STORE_CYC        = STORE_MAX_MS * 1000 * CLK_MHZ;
   localparam int SEQ_LEN          = 6;
   localparam int CNT_W            = 20;

   typedef enum logic [2:0] {
      OP_READ  = 3'h0,
      OP_WRITE = 3'h1,
      OP_PSAVE = 3'h2,
      OP_SEQ   = 3'h3
   } op_t;

   typedef enum logic [2:0] {
      ST_BOOT  = 3'h0,
      ST_IDLE  = 3'h1,
      ST_ACC   = 3'h2,
      ST_GAP   = 3'h3,
      ST_PULSE = 3'h4,
      ST_WAIT  = 3'h5
   } state_t;

   typedef struct packed {
      logic              valid;
      op_t               op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } req_t;

   typedef struct packed {
      logic              ce_n;
      logic              we_n;
      logic              oe_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_o;
      logic              dq_oe_n;
      logic              sb_o;
      logic              sb_oe_n;
   } bus_t;
endpackage

// [nvram_host.sv]
// Host controller driving an asynchronous nonvolatile SRAM over its pins
`timescale 1ns/1ps
module nvram_host
   import nvram_host_pkg::*;
#(
   parameter int RESTORE_WAIT = RESTORE_CYC,     // Power-up restore wait, cycles
   parameter int CMD_WAIT     = SEQ_LATENCY_CYC, // Sequence latency, cycles
   parameter int STORE_WAIT   = STORE_CYC        // Store completion bound, cycles
)(
   input  wire logic                          CLK,         // 40 MHz clock
   input  wire logic                          NRST,        // Sync reset, active low
   input  wire nvram_host_pkg::req_t          REQ,         // Request carrier
   input  wire logic [5:0][ADDR_W-1:0]        SEQ_ADDR,    // Command address table
   input  wire logic                          SLOW_GRADE,  // 1: 45 ns part
   output logic                               REQ_READY,   // Idle, accepts request while pin reads high
   output logic                               DONE,        // Pulse, operation ended
   output logic [DATA_W-1:0]                  RDATA,       // Read data
   output logic                               TIMEOUT,     // Pulse, busy overran bound
   output nvram_host_pkg::bus_t               BUS,         // Device pins out
   input  wire logic [DATA_W-1:0]             DQ_I,        // Data pins in
   input  wire logic                          SB_I         // Store/busy pin in
);
   import nvram_host_pkg::*;

   // ----------------------------------------------------------------
   // Carried state
   // ----------------------------------------------------------------
   typedef struct packed {
      state_t            st;
      op_t               op;
      logic [CNT_W-1:0]  cnt;
      logic [22:0]       wait_cnt;
      logic [2:0]        step;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        sb_sync;
      logic              ready;
      logic              done;
      logic              tout;
      bus_t              bus;
   } host_t;

   host_t s_r;
   host_t s_nxt;
   logic [CNT_W-1:0] acc_len;
   logic             sb_high;

   // ----------------------------------------------------------------
   // Grade timing and pin view
   // ----------------------------------------------------------------
   always_comb begin
      acc_len = SLOW_GRADE ? CNT_W'(READ_CYC_SLOW) : CNT_W'(READ_CYC_FAST);
      sb_high = s_r.sb_sync[1];
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt           = s_r;
      s_nxt.done      = 1'b0;
      s_nxt.tout      = 1'b0;
      s_nxt.sb_sync   = {s_r.sb_sync[0], SB_I};
      unique case (s_r.st)
         ST_BOOT: begin
            // Device restores and ignores us; wait out the worst case
            if (s_r.wait_cnt >= 23'(RESTORE_WAIT - 1)) begin
               s_nxt.st    = ST_IDLE;
               s_nxt.ready = 1'b1;
            end else begin
               s_nxt.wait_cnt = s_r.wait_cnt + 23'h000001;
            end
         end
         ST_IDLE: begin
            // Pin is seen two cycles late; a save begun inside that gap is missed
            if (REQ.valid && sb_high) begin
               s_nxt.ready    = 1'b0;
               s_nxt.op       = REQ.op;
               s_nxt.addr     = REQ.addr;
               s_nxt.wdata    = REQ.wdata;
               s_nxt.step     = 3'h0;
               s_nxt.cnt      = '0;
               s_nxt.bus.addr = (REQ.op == OP_SEQ) ? SEQ_ADDR[0] : REQ.addr;
               if (REQ.op == OP_PSAVE) begin
                  s_nxt.st          = ST_PULSE;
                  s_nxt.bus.sb_o    = 1'b0;
                  s_nxt.bus.sb_oe_n = 1'b0;
               end else if (REQ.op == OP_WRITE) begin
                  s_nxt.st          = ST_ACC;
                  s_nxt.bus.ce_n    = 1'b0;
                  s_nxt.bus.we_n    = 1'b0;
                  s_nxt.bus.dq_o    = REQ.wdata;
                  s_nxt.bus.dq_oe_n = 1'b0;
               end else begin
                  // Read strobes: write strobe left high
                  s_nxt.st       = ST_ACC;
                  s_nxt.bus.ce_n = 1'b0;
                  s_nxt.bus.oe_n = 1'b0;
                  s_nxt.bus.we_n = 1'b1;
               end
            end
         end
         ST_ACC: begin
            if (s_r.cnt >= ((s_r.op == OP_WRITE) ? CNT_W'(WRITE_CYC) : acc_len) - CNT_W'(1)) begin
               s_nxt.bus.ce_n    = 1'b1;
               s_nxt.bus.oe_n    = 1'b1;
               s_nxt.bus.we_n    = 1'b1;
               s_nxt.bus.dq_oe_n = 1'b1;
               s_nxt.cnt         = '0;
               // Read data taken while our own strobes hold it steady: no synchroniser
               // No command read data is kept; only OP_READ loads rdata
               if (s_r.op == OP_READ) begin
                  s_nxt.rdata = DQ_I;
               end
               s_nxt.st = ST_GAP;
            end else begin
               s_nxt.cnt = s_r.cnt + CNT_W'(1);
            end
         end
         ST_GAP: begin
            // One idle cycle with CE high between strobes; the next address is set at the same edge as CE falls
            if (s_r.op == OP_SEQ && s_r.step < 3'(SEQ_LEN - 1)) begin
               s_nxt.step     = s_r.step + 3'h1;
               s_nxt.bus.addr = SEQ_ADDR[s_r.step + 3'h1];
               s_nxt.bus.ce_n = 1'b0;
               s_nxt.bus.oe_n = 1'b0;
               s_nxt.st       = ST_ACC;
            end else if (s_r.op == OP_SEQ) begin
               s_nxt.cnt      = '0;
               s_nxt.wait_cnt = '0;
               s_nxt.st       = ST_WAIT;
            end else begin
               s_nxt.done  = 1'b1;
               s_nxt.ready = 1'b1;
               s_nxt.st    = ST_IDLE;
            end
         end
         ST_PULSE: begin
            // One cycle already exceeds the minimum pulse at this clock
            if (s_r.cnt >= CNT_W'(SAVE_PULSE_CYC - 1)) begin
               // Release; the pin then rests on the device's weak pull-up
               s_nxt.bus.sb_oe_n = 1'b1;
               s_nxt.bus.sb_o    = 1'b1;
               s_nxt.wait_cnt    = '0;
               s_nxt.st          = ST_WAIT;
            end else begin
               s_nxt.cnt = s_r.cnt + CNT_W'(1);
            end
         end
         ST_WAIT: begin
            // Sequence: fixed latency, then follow busy; pin save: follow busy
            // Synchroniser still holds the level from before our pulse: skip one cycle
            if (s_r.op == OP_SEQ && s_r.cnt < CNT_W'(CMD_WAIT)) begin
               s_nxt.cnt = s_r.cnt + CNT_W'(1);
            end else if (sb_high && s_r.wait_cnt != '0) begin
               s_nxt.done  = 1'b1;
               s_nxt.ready = 1'b1;
               s_nxt.st    = ST_IDLE;
            end else if (s_r.wait_cnt >= 23'(STORE_WAIT)) begin
               s_nxt.tout  = 1'b1;
               s_nxt.done  = 1'b1;
               s_nxt.ready = 1'b1;
               s_nxt.st    = ST_IDLE;
            end else begin
               s_nxt.wait_cnt = s_r.wait_cnt + 23'h000001;
            end
         end
         default: s_nxt.st = ST_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         s_r             <= '0;
         s_r.st          <= ST_BOOT;
         s_r.bus.ce_n    <= 1'b1;
         s_r.bus.we_n    <= 1'b1;
         s_r.bus.oe_n    <= 1'b1;
         s_r.bus.dq_oe_n <= 1'b1;
         s_r.bus.sb_o    <= 1'b1;
         s_r.bus.sb_oe_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_comb begin
      REQ_READY = s_r.ready;
      DONE      = s_r.done;
      RDATA     = s_r.rdata;
      TIMEOUT   = s_r.tout;
      BUS       = s_r.bus;
   end
endmodule // nvram_host

// [nvram_host_chk.sv]
// Checker: pin-level assertions on the host controller
`timescale 1ns/1ps
module nvram_host_chk
   import nvram_host_pkg::*;
#(parameter int RESTORE_WAIT = 4)(
   input wire logic                   CLK,        // Clock
   input wire logic                   NRST,       // Reset
   input wire req_t                   REQ,        // Request
   input wire logic [5:0][ADDR_W-1:0] SEQ_ADDR,   // Table
   input wire logic                   SLOW_GRADE, // Grade
   input wire logic                   REQ_READY,  // Idle
   input wire logic                   DONE,       // End
   input wire logic [DATA_W-1:0]      RDATA,      // Data
   input wire logic                   TIMEOUT,    // Overrun
   input wire bus_t                   BUS,        // Pins
   input wire logic [DATA_W-1:0]      DQ_I,       // Data in
   input wire logic                   SB_I        // Pin in
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   int boot_cnt_r;
   always_ff @(posedge CLK) begin
      boot_cnt_r <= !NRST ? 0 : (boot_cnt_r < RESTORE_WAIT ? boot_cnt_r + 1 : boot_cnt_r);
   end
   read_we_high_a: assert property (!BUS.ce_n && !BUS.oe_n |-> BUS.we_n)
      else $error("write strobe low in read");
   access_pin_high_a: assert property (!BUS.ce_n |-> SB_I)
      else $error("access while pin low");
   write_no_gate_a: assert property (!BUS.we_n |-> BUS.oe_n && !BUS.ce_n && !BUS.dq_oe_n)
      else $error("bad write strobes");
   fast_read_len_a: assert property ($fell(BUS.oe_n) && !SLOW_GRADE |=> BUS.oe_n && BUS.ce_n)
      else $error("fast read length");
   slow_read_len_a: assert property ($fell(BUS.oe_n) && SLOW_GRADE |=> !BUS.oe_n ##1 BUS.oe_n)
      else $error("slow read length");
   step_is_read_a: assert property ($fell(BUS.ce_n) && BUS.we_n |-> !BUS.oe_n)
      else $error("select without gate");
   save_pulse_a: assert property ($fell(BUS.sb_oe_n) |-> !BUS.sb_o ##1 BUS.sb_oe_n)
      else $error("save pulse width");
   restore_wait_a: assert property (REQ_READY |-> boot_cnt_r >= RESTORE_WAIT)
      else $error("ready before restore");
   cover property ($fell(BUS.we_n));
   cover property ($fell(BUS.sb_oe_n));
   cover property (TIMEOUT);
endmodule // nvram_host_chk
bind nvram_host nvram_host_chk #(.RESTORE_WAIT(RESTORE_WAIT)) chk (.CLK(CLK), .NRST(NRST), .REQ(REQ),
   .SEQ_ADDR(SEQ_ADDR), .SLOW_GRADE(SLOW_GRADE), .REQ_READY(REQ_READY), .DONE(DONE), .RDATA(RDATA),
   .TIMEOUT(TIMEOUT), .BUS(BUS), .DQ_I(DQ_I), .SB_I(SB_I));

// [nvram_dev_model.sv]
// Behavioural nonvolatile SRAM seen from its pins
`timescale 1ns/1ps
module nvram_dev_model
   import nvram_host_pkg::*;
(
   input  wire logic                   clk,      // Clock
   input  wire bus_t                   bus,      // Host pins
   input  wire logic [5:0][ADDR_W-1:0] cmd_addr, // Command table
   input  wire logic [31:0]            busy_len, // Save length
   output logic [DATA_W-1:0]           dq,       // Data to host
   output logic                        sb        // Pin level
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic dirty = 1'b0;
   logic rd_q = 1'b0;
   // Power-up restore holds the pin low at first
   int busy = 8;
   int step = 0;
   wire rd = !bus.ce_n && bus.we_n && !bus.oe_n;
   // Undriven data shows the inverse, so a stale sample never matches
   assign dq = (rd && busy == 0) ? mem[bus.addr] : ~mem[bus.addr];
   assign sb = busy == 0 && !(!bus.sb_oe_n && !bus.sb_o);
   always @(posedge clk) begin
      rd_q <= rd;
      if (busy > 0) begin
         busy <= busy - 1;
      end else if (!bus.ce_n && !bus.we_n) begin
         mem[bus.addr] <= bus.dq_o;
         dirty <= 1'b1;
      end else if (!bus.sb_oe_n && !bus.sb_o && dirty) begin
         busy <= busy_len;
         dirty <= 1'b0;
      end
      if (rd && !rd_q) step <= bus.addr == cmd_addr[step] ? step + 1 : 0;
      if (step == 6 && !rd) begin
         step <= 0;
         busy <= busy_len;
      end
   end
endmodule // nvram_dev_model

// [nvram_host_test.sv]
// Testbench: host controller against a behavioural device model
`timescale 1ns/1ps
module nvram_host_test;
   import nvram_host_pkg::*;
   logic CLK = 1'b0;
   logic NRST = 1'b0;
   req_t REQ = '0;
   logic [5:0][ADDR_W-1:0] SEQ_ADDR;
   logic SLOW_GRADE = 1'b0;
   logic REQ_READY, DONE, TIMEOUT, SB_I;
   logic [DATA_W-1:0] RDATA, DQ_I;
   bus_t BUS;
   int busy_len = 20;
   int bad_count = 0;
   int n_compared = 0;
   int lat;
   always #12.5 CLK = ~CLK;
   nvram_host #(.RESTORE_WAIT(4), .CMD_WAIT(8), .STORE_WAIT(50)) dut (.CLK(CLK), .NRST(NRST), .REQ(REQ),
      .SEQ_ADDR(SEQ_ADDR), .SLOW_GRADE(SLOW_GRADE), .REQ_READY(REQ_READY), .DONE(DONE), .RDATA(RDATA),
      .TIMEOUT(TIMEOUT), .BUS(BUS), .DQ_I(DQ_I), .SB_I(SB_I));
   nvram_dev_model dev (.clk(CLK), .bus(BUS), .cmd_addr(SEQ_ADDR), .busy_len(busy_len), .dq(DQ_I), .sb(SB_I));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   function automatic int read_lat(input logic slow);
      return (slow ? READ_CYC_SLOW : READ_CYC_FAST) + 2;
   endfunction
   // Two extra edges let the pin pass the two-flop sync
   task automatic run(input op_t op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n = 0;
      while (!(REQ_READY === 1'b1 && SB_I === 1'b1) && n < 3000) begin
         @(posedge CLK);
         #1 n++;
      end
      repeat (2) @(posedge CLK);
      #1 REQ = '{1'b1, op, a, d};
      @(posedge CLK);
      #1 REQ.valid = 1'b0;
      lat = 1;
      while (DONE !== 1'b1 && lat < 3000) begin
         @(posedge CLK);
         #1 lat++;
      end
   endtask
   initial begin
      logic [ADDR_W-1:0] a;
      logic [DATA_W-1:0] d;
      for (int i = 0; i < 6; i++) SEQ_ADDR[i] = ADDR_W'(32'h0E38 + 32'h0753 * i);
      void'($urandom(32'hD0683A01));
      repeat (2) @(posedge CLK);
      #1 NRST = 1'b1;
      for (int i = 0; i < 12; i++) begin
         a = i == 0 ? '0 : i == 1 ? '1 : ADDR_W'($urandom);
         d = DATA_W'($urandom);
         SLOW_GRADE = i[0];
         run(OP_WRITE, a, d);
         run(OP_READ, a, '0);
         chk("read latency", read_lat(i[0]), lat);
         chk("read data", d, RDATA);
      end
      $display("read write test done");
      run(OP_PSAVE, '0, '0);
      chk("dirty save wait", 1, lat > busy_len);
      run(OP_PSAVE, '0, '0);
      chk("clean save wait", 1, lat < busy_len);
      chk("no overrun", 0, TIMEOUT);
      run(OP_WRITE, a, d);
      busy_len = 80;
      run(OP_PSAVE, '0, '0);
      chk("busy overrun", 1, TIMEOUT);
      busy_len = 20;
      $display("save test done");
      for (int g = 0; g < 2; g++) begin
         SLOW_GRADE = g[0];
         run(OP_SEQ, '0, '0);
         chk("sequence wait", 1, lat >= 6 * (g + 2) + busy_len && lat <= 6 * (g + 2) + busy_len + 12);
         chk("sequence keeps data", d, RDATA);
      end
      d = ~d;
      run(OP_WRITE, a, d);
      run(OP_READ, a, '0);
      chk("read after busy", d, RDATA);
      $display("sequence test done");
      stop_test();
   end
   // Run needs about 400 cycles; 8000 allowed
   initial begin
      #200000;
      bad_count++;
      stop_test();
   end
endmodule // nvram_host_test
